// ==== src/wdt_top.sv ====
// watchdog / interval timer: prescaler, down counter, feed checker, reset pulse
//
// Behaviour
// - watchdog mode underflow asserts system reset
// - 12-bit prescaler then 8-bit down counter
// - counter steps on selected prescaler tap pulse
// - source: pclk, 400 kHz oscillator, crystal
// - only power-on reset clears watchdog state
// - reset disabled: interval timer underflow interrupts
// - feed accepted only after both bytes
// - pclk source in power-down: idle, no reset
// - bad or incomplete feed resets in watchdog mode
// - control write must be followed by feed
// - reset enable one selects watchdog mode
`timescale 1ns/1ps
module wdt_top
   import wdt_pkg::*;
#(
   parameter logic [7:0] RST_HOLD = RST_HOLD_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        wdt_osc_clk,
   input  wire logic        xtal_clk,
   input  wire logic        power_down,
   input  wire wdt_access_s access,
   input  wire logic        irq_enable,
   input  wire logic        flag_clear,
   output wdt_status_s      status
);

   typedef struct packed {
      logic [PRESC_W-1:0]  presc;
      logic [COUNT_W-1:0]  count;
      wdt_feed_e           feed;
      wdt_ctrl_s           active;
      wdt_ctrl_s           pending;
      logic [2:0]          osc_sync;
      logic [2:0]          xtal_sync;
      logic                osc_lvl;
      logic                xtal_lvl;
      logic                flag;
      logic                irq;
      logic [7:0]          rst_cnt;
      logic                sys_reset;
   } wdt_state_s;

   wdt_state_s st;
   wdt_state_s next_st;

   logic [3:0]         tap_idx;
   logic [PRESC_W-1:0] tap_mask;
   logic               osc_new;
   logic               xtal_new;
   logic               src_tick;
   logic               frozen;
   logic               tap_pulse;
   logic               underflow;
   logic               feed_ok;
   logic               feed_bad;
   logic               fire;

   always_comb begin
      next_st = st;

      // only the second flop reads the first; levels move when 2nd and 3rd agree
      next_st.osc_sync  = {st.osc_sync[1:0], wdt_osc_clk};
      next_st.xtal_sync = {st.xtal_sync[1:0], xtal_clk};
      osc_new  = st.osc_lvl;
      xtal_new = st.xtal_lvl;
      if (st.osc_sync[1] == st.osc_sync[2]) begin
         osc_new = st.osc_sync[2];
      end
      if (st.xtal_sync[1] == st.xtal_sync[2]) begin
         xtal_new = st.xtal_sync[2];
      end
      next_st.osc_lvl  = osc_new;
      next_st.xtal_lvl = xtal_new;

      // pclk stops in power-down, so the whole chain stands still
      frozen = (st.active.src == WDT_SRC_PCLK) && power_down;

      unique case (st.active.src)
         WDT_SRC_PCLK: src_tick = 1'b1;
         WDT_SRC_OSC:  src_tick = osc_new && !st.osc_lvl;
         WDT_SRC_XTAL: src_tick = xtal_new && !st.xtal_lvl;
         default:      src_tick = 1'b0;
      endcase
      src_tick = src_tick && !frozen;

      // tap k fires when the prescaler bits up to TAP_BASE+k roll over
      tap_idx   = TAP_BASE + {1'b0, st.active.tap};
      tap_mask  = {PRESC_W{1'b1}} >> (TAP_TOP - tap_idx);
      tap_pulse = src_tick && ((st.presc & tap_mask) == tap_mask);
      underflow = tap_pulse && (st.count == '0);

      // feed sequence checker
      feed_ok  = 1'b0;
      feed_bad = 1'b0;
      unique case (st.feed)
         WDT_FEED_IDLE: begin
            if (access.feed_wr) begin
               if (access.feed_data == FEED_FIRST) begin
                  next_st.feed = WDT_FEED_HALF;
               end else begin
                  feed_bad = 1'b1;
               end
            end
         end
         WDT_FEED_HALF: begin
            if (access.feed_wr) begin
               next_st.feed = WDT_FEED_IDLE;
               if (access.feed_data == FEED_SECOND) begin
                  feed_ok = 1'b1;
               end else begin
                  feed_bad = 1'b1;
               end
            end else if (access.ctrl_wr || access.other_wr) begin
               next_st.feed = WDT_FEED_IDLE;
               feed_bad     = 1'b1;
            end
         end
         WDT_FEED_CTRL: begin
            // the very next access after a control write must open a feed
            if (access.feed_wr && access.feed_data == FEED_FIRST) begin
               next_st.feed = WDT_FEED_HALF;
            end else if (access.feed_wr || access.ctrl_wr || access.other_wr) begin
               next_st.feed = WDT_FEED_IDLE;
               feed_bad     = 1'b1;
            end
         end
         default: begin
            next_st.feed = WDT_FEED_IDLE;
         end
      endcase

      // a control write overrides the checker's next state; a feed_bad it raised still stands
      if (access.ctrl_wr && st.feed != WDT_FEED_HALF) begin
         next_st.pending = access.ctrl_data;
         next_st.feed    = WDT_FEED_CTRL;
      end else if (access.ctrl_wr) begin
         next_st.pending = access.ctrl_data;
         next_st.feed    = WDT_FEED_CTRL;
      end

      // 12-bit prescaler into 8-bit down counter
      if (src_tick) begin
         next_st.presc = st.presc + 12'h001;
      end
      if (tap_pulse) begin
         next_st.count = st.count - 8'h01;
      end
      if (underflow) begin
         next_st.count = st.active.reload;
      end

      // new settings take effect with the feed that confirms them
      if (feed_ok) begin
         next_st.active = st.pending;
         next_st.presc  = '0;
         next_st.count  = st.pending.reload;
      end

      // reset mode only with the enable bit at one
      fire = st.active.watchdog_reset_enable && !frozen
             && (underflow || feed_bad);

      // interval timer flag; a new underflow wins over a clear
      if (flag_clear) begin
         next_st.flag = 1'b0;
      end
      if (underflow && !st.active.watchdog_reset_enable) begin
         next_st.flag = 1'b1;
      end
      next_st.irq = next_st.flag && irq_enable;

      // stretched reset pulse towards the rest of the chip
      if (fire) begin
         next_st.rst_cnt   = RST_HOLD;
         next_st.sys_reset = 1'b1;
      end else if (st.rst_cnt != 8'h00) begin
         next_st.rst_cnt   = st.rst_cnt - 8'h01;
         next_st.sys_reset = (st.rst_cnt != 8'h01);
      end else begin
         next_st.sys_reset = 1'b0;
      end
   end

   // reset here is power-on only; the pulse we issue never clears our own state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st.presc     <= '0;
         st.count     <= CTRL_RESET.reload;
         st.feed      <= WDT_FEED_IDLE;
         st.active    <= CTRL_RESET;
         st.pending   <= CTRL_RESET;
         st.osc_sync  <= 3'h0;
         st.xtal_sync <= 3'h0;
         st.osc_lvl   <= 1'b0;
         st.xtal_lvl  <= 1'b0;
         st.flag      <= 1'b0;
         st.irq       <= 1'b0;
         st.rst_cnt   <= 8'h00;
         st.sys_reset <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign status.count        = st.count;
   assign status.timeout_flag = st.flag;
   assign status.irq          = st.irq;
   assign status.sys_reset    = st.sys_reset;
   assign status.reset_mode   = st.active.watchdog_reset_enable;

endmodule // wdt_top

// ==== src/wdt_pkg.sv ====
// shared constants and carrier types for the watchdog interval timer
package wdt_pkg;

   localparam int PRESC_W = 12;
   localparam int COUNT_W = 8;

   // feed sequence bytes; any byte pair would serve
   localparam logic [7:0] FEED_FIRST  = 8'hA5;
   localparam logic [7:0] FEED_SECOND = 8'h5A;

   // tap k taken at prescaler bit TAP_BASE + k
   localparam logic [3:0] TAP_BASE = 4'h4;
   localparam logic [3:0] TAP_TOP  = 4'hB;

   // width of the system reset pulse in ref_clk cycles
   localparam logic [7:0] RST_HOLD_CYCLES = 8'h10;

   typedef enum logic [1:0] {
      WDT_SRC_PCLK = 2'h0,
      WDT_SRC_OSC  = 2'h1,
      WDT_SRC_XTAL = 2'h2
   } wdt_src_e;

   typedef enum logic [1:0] {
      WDT_FEED_IDLE = 2'h0,
      WDT_FEED_HALF = 2'h1,
      WDT_FEED_CTRL = 2'h3
   } wdt_feed_e;

   // contents of watchdog_control_register
   typedef struct packed {
      logic                     watchdog_reset_enable;
      wdt_src_e                 src;
      logic [2:0]               tap;
      logic [COUNT_W-1:0]       reload;
   } wdt_ctrl_s;

   localparam wdt_ctrl_s CTRL_RESET = '{
      watchdog_reset_enable : 1'b0,
      src                   : WDT_SRC_OSC,
      tap                   : 3'h7,
      reload                : 8'hFF
   };

   // software-side accesses, one write per cycle
   typedef struct packed {
      logic                     ctrl_wr;
      wdt_ctrl_s                ctrl_data;
      logic                     feed_wr;
      logic [7:0]               feed_data;
      logic                     other_wr;
   } wdt_access_s;

   typedef struct packed {
      logic [COUNT_W-1:0]       count;
      logic                     timeout_flag;
      logic                     irq;
      logic                     sys_reset;
      logic                     reset_mode;
   } wdt_status_s;

endpackage

// ==== sim/wdt_props.sv ====
// concurrent checks on the watchdog interval timer ports
`timescale 1ns/1ps
module wdt_props
   import wdt_pkg::*;
#(
   parameter logic [7:0] RST_HOLD = RST_HOLD_CYCLES
) (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        power_down,
   input wire wdt_access_s access,
   input wire logic        irq_enable,
   input wire logic        flag_clear,
   input wire wdt_status_s status
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [7:0] hc;
   wire logic  bad = access.feed_wr && access.feed_data != FEED_FIRST && access.feed_data != FEED_SECOND;
   // pulse length counted, too long for a repetition
   always_ff @(posedge ref_clk) hc <= (reset || !status.sys_reset) ? 8'h00 : hc + 8'h01;
   sequence s_feed;
      access.feed_wr && access.feed_data == FEED_FIRST ##1 access.feed_wr && access.feed_data == FEED_SECOND;
   endsequence
   sequence s_ctrl_bad;
      (status.reset_mode && !power_down && access.ctrl_wr) ##1 (access.other_wr && !power_down);
   endsequence
   a_bad_feed_rst: assert property (status.reset_mode && !power_down && bad |=> status.sys_reset)
      else $error("bad feed byte gave no system reset");
   a_ctrl_no_feed: assert property (s_ctrl_bad |=> status.sys_reset)
      else $error("control write without feed gave no reset");
   a_pulse_len: assert property ($fell(status.sys_reset) |-> hc == RST_HOLD)
      else $error("system reset pulse has wrong length");
   a_flag_sticky: assert property (status.timeout_flag && !flag_clear |=> status.timeout_flag)
      else $error("timeout flag dropped without clear");
   // irq is built from the flag's next value, so it rises with the flag
   a_irq_gate: assert property (!$past(reset) |-> status.irq == (status.timeout_flag && $past(irq_enable)))
      else $error("interrupt does not follow flag and enable");
   a_flag_timer: assert property ($rose(status.timeout_flag) |-> !$past(status.reset_mode))
      else $error("flag set in watchdog mode");
   a_rst_mode: assert property ($rose(status.sys_reset) |-> $past(status.reset_mode))
      else $error("system reset outside watchdog mode");
   a_feed_hold: assert property (s_feed |=> ##1 $stable(status.count)[*8])
      else $error("count moved right after a feed");
   a_count_step: assert property (!$past(reset) && !$past(access.feed_wr) && $past(status.count) != 8'h00
      && $changed(status.count) |-> status.count == $past(status.count) - 8'h01)
      else $error("count changed by other than one step");
endmodule // wdt_props
bind wdt_top wdt_props #(.RST_HOLD(RST_HOLD)) u_props (.ref_clk(ref_clk), .reset(reset), .power_down(power_down),
   .access(access), .irq_enable(irq_enable), .flag_clear(flag_clear), .status(status));

// ==== sim/wdt_top_tb.sv ====
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
module wdt_top_tb;
   import wdt_pkg::*;
   typedef struct {wdt_src_e s; logic [2:0] t; logic [7:0] r; logic ie; int n;} wdt_row_s;
   logic        ref_clk = 0;
   logic        reset = 1;
   logic        osc = 0;
   logic        xtal = 0;
   logic        pd = 0;
   logic        irq_en = 0;
   logic        fclr = 0;
   logic        prev = 0;
   wdt_access_s acc = '0;
   // reset mode kept, so the unconfirmed write cannot drop the feed tests into timer mode
   localparam wdt_ctrl_s WD_CFG = '{1'b1, WDT_SRC_PCLK, 3'h7, 8'hFF};
   wdt_status_s st;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          n_rise = 0;
   // n is cycles from feed to underflow
   wdt_row_s rows [4] = '{'{WDT_SRC_PCLK, 3'h0, 8'h00, 1'b1, 32}, '{WDT_SRC_PCLK, 3'h7, 8'h00, 1'b0, 4096},
      '{WDT_SRC_OSC, 3'h0, 8'h00, 1'b1, 128}, '{WDT_SRC_XTAL, 3'h0, 8'h01, 1'b0, 512}};
   wdt_top #(.RST_HOLD(8'h02)) dut_u (.ref_clk(ref_clk), .reset(reset), .wdt_osc_clk(osc), .xtal_clk(xtal),
      .power_down(pd), .access(acc), .irq_enable(irq_en), .flag_clear(fclr), .status(st));
   initial forever #5 ref_clk = ~ref_clk;
   initial begin #3; forever #20 osc = ~osc; end
   initial begin #7; forever #40 xtal = ~xtal; end
   always @(posedge ref_clk) begin
      if (st.sys_reset === 1'b1 && prev !== 1'b1) n_rise++;
      prev = st.sys_reset;
   end
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic put(wdt_access_s a);
      @(posedge ref_clk) acc <= a;
   endtask
   function automatic wdt_access_s fd(logic [7:0] d);
      fd = '0;
      fd.feed_wr = 1'b1;
      fd.feed_data = d;
   endfunction
   task automatic cfg(logic e, wdt_src_e s, logic [2:0] t, logic [7:0] r);
      wdt_access_s a;
      a = '0;
      a.ctrl_wr = 1'b1;
      a.ctrl_data = '{e, s, t, r};
      put(a);
      put(fd(FEED_FIRST));
      put(fd(FEED_SECOND));
      put('0);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      cyc(12000);
      n_mismatch++;
      $display("ERROR watchdog expected done seen hang");
      give_verdict;
   end
   initial begin
      cyc(20);
      reset <= 1'b0;
      cyc(2);
      chk("count", 8'hFF, st.count);
      foreach (rows[i]) begin
         irq_en <= rows[i].ie;
         cfg(1'b0, rows[i].s, rows[i].t, rows[i].r);
         fclr <= 1'b1;
         cyc(1);
         fclr <= 1'b0;
         // margin covers oscillator phase and sync delay
         cyc(rows[i].n - 13);
         chk("flag early", 8'h00, {7'h0, st.timeout_flag});
         cyc(24);
         chk("flag", 8'h01, {7'h0, st.timeout_flag});
         chk("irq", {7'h0, rows[i].ie}, {7'h0, st.irq});
         $display("row %0d done", i);
      end
      cfg(1'b1, WDT_SRC_PCLK, 3'h7, 8'hFF);
      cyc(1);
      chk("mode", 8'h01, {7'h0, st.reset_mode});
      put(fd(8'h33));
      put('0);
      cyc(4);
      chk("bad feed", 8'h01, n_rise[7:0]);
      put('{1'b1, WD_CFG, 1'b0, 8'h00, 1'b0});
      put('{1'b0, CTRL_RESET, 1'b0, 8'h00, 1'b1});
      put('0);
      cyc(4);
      chk("ctrl no feed", 8'h02, n_rise[7:0]);
      put(fd(FEED_FIRST));
      put('0);
      put(fd(FEED_SECOND));
      put('0);
      cyc(4);
      chk("split feed", 8'h02, n_rise[7:0]);
      put(fd(FEED_FIRST));
      put('{1'b0, CTRL_RESET, 1'b0, 8'h00, 1'b1});
      put('0);
      cyc(4);
      chk("half feed", 8'h03, n_rise[7:0]);
      chk("mode kept", 8'h01, {7'h0, st.reset_mode});
      $display("feed tests done");
      cfg(1'b1, WDT_SRC_PCLK, 3'h0, 8'h00);
      pd <= 1'b1;
      cyc(100);
      chk("power down", 8'h03, n_rise[7:0]);
      pd <= 1'b0;
      cyc(45);
      chk("underflow", 8'h04, n_rise[7:0]);
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      cyc(2);
      chk("mode cleared", 8'h00, {7'h0, st.reset_mode});
      chk("count reset", 8'hFF, st.count);
      $display("reset tests done");
      give_verdict;
   end
endmodule // wdt_top_tb
